/* File: hw/lsau_extend.sv */
// Sign or zero extension of narrow loaded data
`timescale 1ns/100ps
module lsau_extend
   import lsau_pkg::*;
(
   input wire lsau_size_type size,
   input wire logic sign_ext,
   input wire logic [31:0] raw,
   output logic [31:0] result
);
   always_comb begin
      case (size)
         LSAU_SZ_BYTE: result = {{24{sign_ext & raw[7]}}, raw[7:0]}; // [RULE7]
         LSAU_SZ_HALF: result = {{16{sign_ext & raw[15]}}, raw[15:0]}; // [RULE7]
         default: result = raw;
      endcase
   end
endmodule

/* File: hw/lsau_params.svh */
// Constants for the load/store address unit
`ifndef LSAU_PARAMS_SVH
`define LSAU_PARAMS_SVH
`define LSAU_PC_AHEAD 32'h0000_0004
`define LSAU_WORD_STEP 32'h0000_0004
`define LSAU_ADR_MAX 12'hfff
`define LSAU_IMM_MAX 12'hfff
`define LSAU_DUAL_MAX 12'h3fc
`define LSAU_SHIFT_MAX 2'h3
`define LSAU_PC_REG 4'hf
`define LSAU_XFER_NS 25
`endif

/* File: hw/lsau_pkg.sv */
// Types for the load/store address unit
package lsau_pkg;
   typedef enum logic [3:0] {
      LSAU_OP_ADR,
      LSAU_OP_LOAD,
      LSAU_OP_STORE,
      LSAU_OP_LOAD_UNPRIV,
      LSAU_OP_STORE_UNPRIV,
      LSAU_OP_LOAD_MULTI,
      LSAU_OP_STORE_MULTI
   } lsau_op_type;
   // Every assembler name of a multiple transfer, mapped onto two directions
   typedef enum logic [2:0] {
      LSAU_MM_LOAD_INCR_AFTER,
      LSAU_MM_LOAD_FULL_DESC,
      LSAU_MM_LOAD_DECR_BEFORE,
      LSAU_MM_LOAD_EMPTY_ASC,
      LSAU_MM_STORE_INCR_AFTER,
      LSAU_MM_STORE_EMPTY_ASC,
      LSAU_MM_STORE_DECR_BEFORE,
      LSAU_MM_STORE_FULL_DESC
   } lsau_mm_type;
   typedef enum logic [1:0] {
      LSAU_IDX_OFFSET,
      LSAU_IDX_PRE,
      LSAU_IDX_POST
   } lsau_idx_type;
   typedef enum logic [1:0] {
      LSAU_SZ_BYTE,
      LSAU_SZ_HALF,
      LSAU_SZ_WORD,
      LSAU_SZ_DUAL
   } lsau_size_type;
   typedef struct packed {
      lsau_op_type op;
      lsau_mm_type mm;
      lsau_idx_type idx;
      lsau_size_type size;
      logic sign_ext;
      logic use_pc;
      logic reg_offset;
      logic subtract;
      logic [11:0] imm;
      logic [1:0] shift;
      logic writeback;
      logic [3:0] xfer_reg;
      logic [15:0] reg_list;
      logic [31:0] base;
      logic [31:0] index;
      logic [31:0] pc;
   } lsau_req_type;
   typedef struct packed {
      logic valid;
      logic write;
      logic unpriv;
      lsau_size_type size;
      logic [31:0] addr;
      logic [3:0] reg_num;
   } lsau_mem_type;
endpackage

/* File: hw/lsau_top.sv */
// Address generation and sequencing for memory access instructions
//
// Contract
// RULE1: PC-relative address adds immediate to PC, writes destination, flags kept.
// RULE2: Program keeps that target within 4095 bytes of PC.
// RULE3: Program never targets stack pointer or PC with it.
// RULE4: Offset mode accesses base plus/minus offset, base unchanged.
// RULE5: Pre-indexed accesses base plus/minus offset and writes it back.
// RULE6: Post-indexed accesses base, then writes base plus/minus offset back.
// RULE7: Byte, halfword, word and dual sizes; narrow loads signed or unsigned.
// RULE8: Register offset address is base plus index shifted left 0..3.
// RULE9: Word load into PC branches to value with bit 0 cleared.
// RULE10: Program puts conditional PC loads last in conditional block.
// RULE11: Unprivileged variants act like immediate forms with unprivileged access.
// RULE12: PC-relative loads take 4095 offsets, dual loads 1020.
// RULE13: Program restricts SP/PC destinations; dual destinations differ.
// RULE14: Increment-after steps up by 4 from base; writeback base+4*(n-1).
// RULE15: Decrement-before steps down by 4 from base; writeback base-4*(n-1).
// RULE16: Multiple-transfer names map onto increment-after or decrement-before.
// RULE17: Program keeps PC out of store lists, not PC with LR.
// RULE18: Program keeps PC out of store lists and SP out of all.
// RULE19: No memory access instruction changes condition flags.
// RULE20: PC operand is instruction address plus 4 with bit 1 cleared.
// RULE21: Only single word/halfword may be unaligned; others raise usage fault.
// RULE22: Empty multiple-transfer list is undefined, no access made.
`timescale 1ns/100ps
`include "lsau_params.svh"
module lsau_top
   import lsau_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic req_valid,
   input wire lsau_req_type req,
   input wire logic mem_ready,
   input wire logic [31:0] mem_rdata,
   output lsau_mem_type mem,
   output logic busy,
   output logic rd_valid,
   output logic [3:0] rd_num,
   output logic [31:0] rd_data,
   output logic wb_valid,
   output logic [31:0] wb_data,
   output logic branch_valid,
   output logic [31:0] branch_target,
   output logic usage_fault,
   output logic undef_fault,
   output logic flags_write
);
   typedef enum {ST_IDLE, ST_ACCESS, ST_SECOND} lsau_state_type;

   function automatic logic [31:0] lsau_apply(input logic [31:0] a, input logic [31:0] off,
                                              input logic sub);
      lsau_apply = sub ? a - off : a + off;
   endfunction

   function automatic logic [4:0] lsau_count(input logic [15:0] l);
      logic [4:0] c;
      c = 5'h0;
      for (int i = 0; i < 16; i++) begin
         c = c + {4'h0, l[i]};
      end
      lsau_count = c;
   endfunction

   lsau_state_type state, next_state;
   lsau_mem_type next_mem;
   lsau_req_type cur, next_cur;
   logic [15:0] remain, next_remain;
   logic next_busy, next_rd_valid, next_wb_valid, next_branch_valid;
   logic next_usage_fault, next_undef_fault;
   logic [3:0] next_rd_num;
   logic [31:0] next_rd_data, next_wb_data, next_branch_target;
   logic [31:0] pc_val, base_val, off_val, eff, upd, mm_start, mm_end, ext_data;
   logic [4:0] n_regs;
   logic [3:0] low_reg;
   logic is_incr, unaligned;

   lsau_extend u_ext (
      .size(cur.size),
      .sign_ext(cur.sign_ext),
      .raw(mem_rdata),
      .result(ext_data)
   );

   always_comb begin
      pc_val = (req.pc + `LSAU_PC_AHEAD) & ~32'h0000_0002; // [RULE20]
      base_val = req.use_pc ? pc_val : req.base;
      if (req.reg_offset) begin
         off_val = req.index << req.shift; // [RULE8]
      end else if (req.use_pc && req.size == LSAU_SZ_DUAL) begin
         off_val = {20'h0, (req.imm > `LSAU_DUAL_MAX) ? `LSAU_DUAL_MAX : req.imm}; // [RULE12]
      end else begin
         off_val = {20'h0, req.imm}; // [RULE12]
      end
      upd = lsau_apply(base_val, off_val, req.subtract & ~req.reg_offset);
      eff = (req.idx == LSAU_IDX_POST) ? base_val : upd; // [RULE4] [RULE5] [RULE6]
      n_regs = lsau_count(req.reg_list);
      is_incr = (req.mm == LSAU_MM_LOAD_INCR_AFTER) || (req.mm == LSAU_MM_LOAD_FULL_DESC) ||
                (req.mm == LSAU_MM_STORE_INCR_AFTER) ||
                (req.mm == LSAU_MM_STORE_EMPTY_ASC); // [RULE16]
      mm_end = is_incr ? req.base + {25'h0, n_regs - 5'h1, 2'h0} // [RULE14]
                       : req.base - {25'h0, n_regs - 5'h1, 2'h0}; // [RULE15]
      mm_start = is_incr ? req.base : mm_end;
      low_reg = 4'h0;
      for (int i = 15; i >= 0; i--) begin
         if (remain[i]) begin
            low_reg = 4'(i);
         end
      end
      // Single words and halfwords may sit on any byte; only the dual form and multiple transfers must align
      case (req.size)
         LSAU_SZ_DUAL: unaligned = |eff[1:0]; // [RULE21]
         default: unaligned = 1'b0;
      endcase
      if (req.op == LSAU_OP_LOAD_MULTI || req.op == LSAU_OP_STORE_MULTI) begin
         unaligned = |req.base[1:0]; // [RULE21]
      end
   end

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_remain = remain;
      next_mem = mem;
      next_busy = busy;
      next_rd_valid = 1'b0;
      next_rd_num = rd_num;
      next_rd_data = rd_data;
      next_wb_valid = 1'b0;
      next_wb_data = wb_data;
      next_branch_valid = 1'b0;
      next_branch_target = branch_target;
      next_usage_fault = 1'b0;
      next_undef_fault = 1'b0;
      case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_cur = req;
               if (req.op == LSAU_OP_ADR) begin
                  next_rd_valid = 1'b1; // [RULE1]
                  next_rd_num = req.xfer_reg;
                  next_rd_data = lsau_apply(pc_val, {20'h0, req.imm}, req.subtract); // [RULE1]
               end else if ((req.op == LSAU_OP_LOAD_MULTI || req.op == LSAU_OP_STORE_MULTI)
                            && req.reg_list == 16'h0) begin
                  next_undef_fault = 1'b1; // [RULE22]
               end else if (unaligned) begin
                  next_usage_fault = 1'b1; // [RULE21]
               end else if (req.op == LSAU_OP_LOAD_MULTI || req.op == LSAU_OP_STORE_MULTI) begin
                  next_remain = req.reg_list;
                  next_cur.base = mm_start;
                  next_cur.index = mm_end;
                  next_mem.valid = 1'b0;
                  next_busy = 1'b1;
                  next_state = ST_ACCESS;
               end else begin
                  next_remain = 16'h0;
                  next_mem.valid = 1'b1;
                  next_mem.write = (req.op == LSAU_OP_STORE) || (req.op == LSAU_OP_STORE_UNPRIV);
                  next_mem.unpriv = (req.op == LSAU_OP_LOAD_UNPRIV) ||
                                    (req.op == LSAU_OP_STORE_UNPRIV); // [RULE11]
                  next_mem.size = (req.size == LSAU_SZ_DUAL) ? LSAU_SZ_WORD : req.size;
                  next_mem.addr = eff;
                  next_mem.reg_num = req.xfer_reg;
                  next_cur.index = upd;
                  next_busy = 1'b1;
                  next_state = ST_ACCESS;
               end
            end
         end
         ST_ACCESS: begin
            if (!mem.valid) begin
               next_mem.valid = 1'b1;
               next_mem.write = (cur.op == LSAU_OP_STORE_MULTI);
               next_mem.unpriv = 1'b0;
               next_mem.size = LSAU_SZ_WORD;
               next_mem.addr = cur.base;
               next_mem.reg_num = low_reg;
               next_remain[low_reg] = 1'b0;
            end else if (mem_ready) begin
               if (!mem.write) begin
                  if (mem.reg_num == `LSAU_PC_REG && mem.size == LSAU_SZ_WORD) begin
                     next_branch_valid = 1'b1; // [RULE9]
                     next_branch_target = {mem_rdata[31:1], 1'b0}; // [RULE9]
                  end else begin
                     next_rd_valid = 1'b1;
                     next_rd_num = mem.reg_num;
                     next_rd_data = ext_data; // [RULE7]
                  end
               end
               if (cur.op != LSAU_OP_LOAD_MULTI && cur.op != LSAU_OP_STORE_MULTI &&
                   cur.size == LSAU_SZ_DUAL && state == ST_ACCESS && remain == 16'h0 &&
                   mem.reg_num == cur.xfer_reg) begin
                  next_mem.addr = mem.addr + `LSAU_WORD_STEP; // [RULE7]
                  next_mem.reg_num = cur.reg_list[3:0];
                  next_state = ST_SECOND;
               end else if (remain != 16'h0) begin
                  next_mem.addr = mem.addr + `LSAU_WORD_STEP; // [RULE14] [RULE15]
                  next_mem.reg_num = low_reg;
                  next_remain[low_reg] = 1'b0;
               end else begin
                  next_mem.valid = 1'b0;
                  next_busy = 1'b0;
                  next_state = ST_IDLE;
                  if (cur.op == LSAU_OP_LOAD_MULTI || cur.op == LSAU_OP_STORE_MULTI) begin
                     next_wb_valid = cur.writeback;
                     next_wb_data = cur.index; // [RULE14] [RULE15]
                  end else begin
                     next_wb_valid = (cur.idx != LSAU_IDX_OFFSET) && !cur.use_pc; // [RULE4]
                     next_wb_data = cur.index; // [RULE5] [RULE6]
                  end
               end
            end
         end
         ST_SECOND: begin
            if (mem_ready) begin
               if (!mem.write) begin
                  next_rd_valid = 1'b1;
                  next_rd_num = mem.reg_num;
                  next_rd_data = mem_rdata;
               end
               next_mem.valid = 1'b0;
               next_busy = 1'b0;
               next_wb_valid = (cur.idx != LSAU_IDX_OFFSET) && !cur.use_pc;
               next_wb_data = cur.index;
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         cur <= '0;
         remain <= 16'h0;
         mem <= '0;
         busy <= 1'b0;
         rd_valid <= 1'b0;
         rd_num <= 4'h0;
         rd_data <= 32'h0;
         wb_valid <= 1'b0;
         wb_data <= 32'h0;
         branch_valid <= 1'b0;
         branch_target <= 32'h0;
         usage_fault <= 1'b0;
         undef_fault <= 1'b0;
         flags_write <= 1'b0; // [RULE19]
      end else begin
         state <= next_state;
         cur <= next_cur;
         remain <= next_remain;
         mem <= next_mem;
         busy <= next_busy;
         rd_valid <= next_rd_valid;
         rd_num <= next_rd_num;
         rd_data <= next_rd_data;
         wb_valid <= next_wb_valid;
         wb_data <= next_wb_data;
         branch_valid <= next_branch_valid;
         branch_target <= next_branch_target;
         usage_fault <= next_usage_fault;
         undef_fault <= next_undef_fault;
         flags_write <= 1'b0; // [RULE19]
      end
   end

   a_flags_kept: assert property (@(posedge mclk) disable iff (rst)
      !flags_write) else $error("flags written"); // [RULE19]
   a_branch_even: assert property (@(posedge mclk) disable iff (rst)
      branch_valid |-> !branch_target[0]) else $error("branch target odd"); // [RULE9]
   a_empty_undef: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_IDLE && req_valid && req.reg_list == 16'h0 &&
       (req.op == LSAU_OP_LOAD_MULTI || req.op == LSAU_OP_STORE_MULTI))
      |=> undef_fault && !mem.valid) else $error("empty list accessed"); // [RULE22]
   a_mm_step: assert property (@(posedge mclk) disable iff (rst)
      (mem.valid && mem_ready && remain != 16'h0 && state == ST_ACCESS &&
       cur.op == LSAU_OP_LOAD_MULTI) |=> mem.addr == $past(mem.addr) + 32'h4)
      else $error("multi step not 4"); // [RULE14]
   a_unpriv_flag: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_IDLE && req_valid && req.op == LSAU_OP_LOAD_UNPRIV && !unaligned)
      |=> mem.unpriv) else $error("unprivileged not flagged"); // [RULE11]
   a_adr_sum: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_IDLE && req_valid && req.op == LSAU_OP_ADR && !req.subtract)
      |=> rd_valid && rd_data == $past(pc_val) + {20'h0, $past(req.imm)})
      else $error("address sum wrong"); // [RULE1]
   a_pc_align: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_IDLE && req_valid && req.op == LSAU_OP_ADR && req.imm[1:0] == 2'h0)
      |=> rd_data[1:0] == {1'b0, $past(req.pc[0])}) else $error("pc bit 1 set"); // [RULE20]
   a_post_addr: assert property (@(posedge mclk) disable iff (rst)
      (state == ST_IDLE && req_valid && req.op == LSAU_OP_LOAD && req.idx == LSAU_IDX_POST
       && !unaligned) |=> mem.addr == $past(base_val)) else $error("post index address"); // [RULE6]
   a_fault_blocks: assert property (@(posedge mclk) disable iff (rst)
      usage_fault |-> !mem.valid && !busy) else $error("fault with access"); // [RULE21]
endmodule

/* File: testbench/lsau_mem_model.sv */
// Memory system model answering the unit's data beats
`timescale 1ns/100ps
module lsau_mem_model
   import lsau_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire lsau_mem_type mem,
   input wire logic [3:0] wait_cycles,
   output logic mem_ready,
   output logic [31:0] mem_rdata
);
   localparam logic [31:0] PAT = 32'h3c5a_80f1;
   logic [3:0] cnt;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
         mem_ready <= 1'b0;
         mem_rdata <= 32'h0;
      end else if (mem.valid && !mem_ready && cnt >= wait_cycles) begin
         mem_ready <= 1'b1;
         // Data is a function of the address; bit 0 set at even addresses so PC loads are legal
         mem_rdata <= mem.addr ^ PAT;
         cnt <= 4'h0;
      end else begin
         mem_ready <= 1'b0;
         // Released bus toggles so a stale value is never mistaken for data
         mem_rdata <= ~mem_rdata;
         cnt <= (mem.valid && !mem_ready) ? cnt + 4'h1 : 4'h0;
      end
   end
endmodule

/* File: testbench/tb.sv */
// Self-checking bench for the load/store address unit
`timescale 1ns/100ps
`define CHECK_EQ(what, exp, got) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("mismatch %s expected %h seen %h", what, exp, got); \
      end \
   end
module tb
   import lsau_pkg::*;
;
   localparam logic [31:0] PAT = 32'h3c5a_80f1;
   logic mclk, rst, req_valid, mem_ready, busy, rd_valid, wb_valid, branch_valid;
   logic usage_fault, undef_fault, flags_write;
   logic [31:0] mem_rdata, rd_data, wb_data, branch_target, last_rd, last_wb, last_br;
   logic [3:0] rd_num, wait_cycles;
   lsau_req_type req;
   lsau_mem_type mem;
   // Event counts: 0 reg write, 1 writeback, 2 branch, 3 usage fault, 4 undefined
   int ev[0:4];
   int bad_count, total_checks, n_flag;
   logic [31:0] b_addr[$];
   logic [3:0] b_reg[$];
   logic b_unpriv[$];
   logic b_write[$];

   lsau_top dut (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req(req),
      .mem_ready(mem_ready), .mem_rdata(mem_rdata), .mem(mem), .busy(busy),
      .rd_valid(rd_valid), .rd_num(rd_num), .rd_data(rd_data), .wb_valid(wb_valid),
      .wb_data(wb_data), .branch_valid(branch_valid), .branch_target(branch_target),
      .usage_fault(usage_fault), .undef_fault(undef_fault), .flags_write(flags_write));
   lsau_mem_model mem_model (.mclk(mclk), .rst(rst), .mem(mem),
      .wait_cycles(wait_cycles), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

   always @(posedge mclk) begin
      if (!rst) begin
         if (mem.valid === 1'b1 && mem_ready === 1'b1) begin
            b_addr.push_back(mem.addr);
            b_reg.push_back(mem.reg_num);
            b_unpriv.push_back(mem.unpriv);
            b_write.push_back(mem.write);
         end
         if (rd_valid === 1'b1) begin
            ev[0]++;
            last_rd = rd_data;
         end
         if (wb_valid === 1'b1) begin
            ev[1]++;
            last_wb = wb_data;
         end
         if (branch_valid === 1'b1) begin
            ev[2]++;
            last_br = branch_target;
         end
         if (usage_fault === 1'b1) ev[3]++;
         if (undef_fault === 1'b1) ev[4]++;
         if (flags_write !== 1'b0) n_flag++;
      end
   end

   function automatic lsau_req_type mk(lsau_op_type op, lsau_size_type sz, logic [31:0] b);
      mk = '0;
      mk.op = op;
      mk.size = sz;
      mk.base = b;
      mk.xfer_reg = 4'h2;
      mk.pc = 32'h0000_1002;
   endfunction

   task automatic send(input lsau_req_type r);
      b_addr.delete();
      b_reg.delete();
      b_unpriv.delete();
      b_write.delete();
      ev = '{default: 0};
      @(negedge mclk);
      req = r;
      req_valid = 1'b1;
      @(negedge mclk);
      req_valid = 1'b0;
      @(negedge mclk);
      for (int i = 0; i < 200 && busy === 1'b1; i++) @(negedge mclk);
      // Let the closing pulses reach the monitor
      repeat (2) @(negedge mclk);
   endtask

   task automatic s_adr;
      lsau_req_type r;
      // Targets stay in range and never name SP or PC
      r = mk(LSAU_OP_ADR, LSAU_SZ_WORD, 32'h0);
      r.imm = 12'hfff;
      r.subtract = 1'b1;
      send(r);
      `CHECK_EQ("adr sub", 32'h0000_1004 - 32'h0000_0fff, last_rd)
      r.subtract = 1'b0;
      r.pc = 32'h0000_2000;
      send(r);
      `CHECK_EQ("adr add", 32'h0000_3003, last_rd)
      `CHECK_EQ("adr reg", 4'h2, rd_num)
      r.pc = 32'h0000_2006;
      r.imm = 12'h004;
      send(r);
      `CHECK_EQ("adr aligned", 32'h0000_200c, last_rd)
   endtask

   task automatic s_index;
      lsau_req_type r;
      logic [31:0] s;
      for (int m = 0; m < 3; m++) begin
         r = mk(LSAU_OP_LOAD, LSAU_SZ_WORD, 32'h1000_0100);
         r.idx = lsau_idx_type'(m);
         r.imm = 12'h0fc;
         r.subtract = m[0];
         r.writeback = (m != 0);
         send(r);
         s = m[0] ? 32'h1000_0004 : 32'h1000_01fc;
         `CHECK_EQ("index addr", (m == 2) ? 32'h1000_0100 : s, b_addr[0])
         `CHECK_EQ("index wb count", (m == 0) ? 0 : 1, ev[1])
         if (m != 0) `CHECK_EQ("index wb", s, last_wb)
      end
   endtask

   task automatic s_size;
      lsau_req_type r;
      logic [31:0] w, e;
      w = 32'h2000_0000 ^ PAT;
      for (int k = 0; k < 4; k++) begin
         r = mk(LSAU_OP_LOAD, lsau_size_type'(k[1]), 32'h2000_0000);
         r.sign_ext = k[0];
         send(r);
         e = k[1] ? {{16{k[0] & w[15]}}, w[15:0]} : {{24{k[0] & w[7]}}, w[7:0]};
         `CHECK_EQ("narrow load", e, last_rd)
      end
      // Two destinations differ
      r = mk(LSAU_OP_LOAD, LSAU_SZ_DUAL, 32'h3000_0008);
      r.imm = 12'h008;
      r.xfer_reg = 4'h4;
      r.reg_list = 16'h0005;
      send(r);
      `CHECK_EQ("dual first", 32'h3000_0010, b_addr[0])
      `CHECK_EQ("dual second", 32'h3000_0014, b_addr[1])
      `CHECK_EQ("dual reg", 4'h5, b_reg[1])
   endtask

   task automatic s_misc;
      lsau_req_type r;
      for (int sh = 0; sh < 4; sh++) begin
         r = mk(LSAU_OP_LOAD, LSAU_SZ_BYTE, 32'h4000_0000);
         r.reg_offset = 1'b1;
         r.index = 32'h0000_0013;
         r.shift = sh[1:0];
         send(r);
         `CHECK_EQ("reg offset", 32'h4000_0000 + (32'h13 << sh), b_addr[0])
      end
      // Branching load is issued unconditionally, so it is trivially last in its block
      r = mk(LSAU_OP_LOAD, LSAU_SZ_WORD, 32'h5000_0000);
      r.xfer_reg = 4'hf;
      send(r);
      `CHECK_EQ("pc load target", (32'h5000_0000 ^ PAT) & ~32'h1, last_br)
      `CHECK_EQ("pc load branch", 1, ev[2])
      for (int k = 0; k < 3; k++) begin
         r = mk((k == 0) ? LSAU_OP_LOAD_UNPRIV : (k == 1) ? LSAU_OP_STORE_UNPRIV
            : LSAU_OP_STORE, LSAU_SZ_WORD, 32'h5000_0100);
         r.idx = LSAU_IDX_PRE;
         r.imm = 12'h004;
         r.writeback = 1'b1;
         send(r);
         `CHECK_EQ("unpriv", (k < 2), b_unpriv[0])
         `CHECK_EQ("unpriv addr", 32'h5000_0104, b_addr[0])
         `CHECK_EQ("unpriv write", (k != 0), b_write[0])
      end
      r = mk(LSAU_OP_LOAD, LSAU_SZ_WORD, 32'h0);
      r.use_pc = 1'b1;
      r.imm = 12'hfff;
      send(r);
      `CHECK_EQ("pc rel word", 32'h0000_2003, b_addr[0])
      r.size = LSAU_SZ_DUAL;
      r.imm = 12'h3fc;
      r.subtract = 1'b1;
      r.reg_list = 16'h0003;
      send(r);
      `CHECK_EQ("pc rel dual", 32'h0000_0c08, b_addr[0])
      `CHECK_EQ("pc rel no wb", 0, ev[1])
   endtask

   task automatic s_multi;
      lsau_req_type r;
      int pos;
      wait_cycles = 4'h2;
      for (int k = 0; k < 8; k++) begin
         r = mk((k < 4) ? LSAU_OP_LOAD_MULTI : LSAU_OP_STORE_MULTI, LSAU_SZ_WORD,
            32'h6000_0040);
         r.mm = lsau_mm_type'(k);
         // Lists hold neither SP nor PC
         r.reg_list = 16'h0214;
         r.writeback = 1'b1;
         send(r);
         `CHECK_EQ("multi beats", 3, b_addr.size())
         for (int j = 0; j < 3; j++) begin
            pos = (b_reg[j] === 4'h2) ? 0 : (b_reg[j] === 4'h4) ? 1 : 9;
            if (b_reg[j] === 4'h9) pos = 2;
            `CHECK_EQ("multi addr", k[1] ? 32'h6000_0040 - 32'(4 * (2 - pos))
               : 32'h6000_0040 + 32'(4 * pos), b_addr[j])
            `CHECK_EQ("multi dir", k[2], b_write[j])
         end
         `CHECK_EQ("multi wb", k[1] ? 32'h6000_0038 : 32'h6000_0048, last_wb)
      end
      wait_cycles = 4'h0;
   endtask

   task automatic s_fault;
      lsau_req_type r;
      r = mk(LSAU_OP_LOAD_MULTI, LSAU_SZ_WORD, 32'h7000_0000);
      send(r);
      `CHECK_EQ("empty list", 1, ev[4])
      `CHECK_EQ("empty no beat", 0, b_addr.size())
      r = mk(LSAU_OP_LOAD, LSAU_SZ_DUAL, 32'h7000_0002);
      r.reg_list = 16'h0003;
      send(r);
      `CHECK_EQ("dual unaligned", 1, ev[3])
      `CHECK_EQ("dual no beat", 0, b_addr.size())
      r.size = LSAU_SZ_WORD;
      send(r);
      `CHECK_EQ("word unaligned ok", 0, ev[3])
      `CHECK_EQ("word unaligned addr", 32'h7000_0002, b_addr[0])
      r.size = LSAU_SZ_HALF;
      r.base = 32'h7000_0001;
      send(r);
      `CHECK_EQ("half unaligned ok", 0, ev[3])
      `CHECK_EQ("half unaligned addr", 32'h7000_0001, b_addr[0])
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial begin
      // Whole run is well under a hundred requests of a few dozen cycles
      #(25 * 20000);
      bad_count++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      wait_cycles = 4'h0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      s_adr();
      s_index();
      s_size();
      s_misc();
      s_multi();
      s_fault();
      `CHECK_EQ("flag writes", 0, n_flag)
      print_verdict();
   end
endmodule
